// ---- design/isc_pkg.sv ----
// Purpose: shared constants and types of the i2c slave controller with interrupt enables
// Assumes: 100 MHz pclk, 32-bit apb data, byte-addressed word registers
// Notes:   every offset, field position, reset value and timing count lives here
`default_nettype none
package isc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus and register map
  localparam int unsigned APB_AW   = 8;
  localparam logic [7:0]  OFS_CTRL = 8'h00;  // slave_control_reg
  localparam logic [7:0]  OFS_ADDR = 8'h04;  // slave_address_reg
  localparam logic [7:0]  OFS_STAT = 8'h08;  // sticky event flags, write one to clear
  localparam logic [7:0]  OFS_DATA = 8'h0c;  // read: received byte, write: byte to send
  localparam logic [7:0]  OFS_MASK = 8'h10;  // enables in flag layout, alias of ctrl bits

  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  ADDR_RST = 8'h00;
  localparam logic [7:0]  DATA_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // control fields
  localparam int unsigned CTRL_SRST    = 7;  // slave_soft_reset
  localparam int unsigned CTRL_EN_LSB  = 2;  // enables occupy ctrl[6:2] in flag order
  localparam int unsigned CTRL_STRETCH = 1;  // clock_stretch_enable
  localparam int unsigned CTRL_FILT    = 0;  // input noise filter enable
  localparam int unsigned ADDR_EN_BIT  = 7;  // slave address enable

  ////////////////////////////////////////////////////////////////////////////////
  // event flags (status and mask layout)
  localparam int unsigned FLG_N       = 5;
  localparam int unsigned FLG_ADDR    = 4;   // addr_match_flag
  localparam int unsigned FLG_STOP    = 3;   // stop_seen_flag
  localparam int unsigned FLG_RESTART = 2;   // restart_seen_flag
  localparam int unsigned FLG_TX      = 1;   // tx_byte_flag
  localparam int unsigned FLG_RX      = 0;   // rx_byte_flag
  localparam int unsigned STAT_XMT    = 5;   // transmit direction, read only
  localparam logic [4:0]  FLG_RST     = 5'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_MHZ  = 100;
  localparam int unsigned FILT_NS  = 50;
  localparam int unsigned FILT_CYC = (FILT_NS * CLK_MHZ) / 1000;

  ////////////////////////////////////////////////////////////////////////////////
  // slave sequencer states
  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_ADDR  = 10'h002,
    ST_AACK  = 10'h004,
    ST_RX    = 10'h008,
    ST_RSTR  = 10'h010,
    ST_RACK  = 10'h020,
    ST_RNACK = 10'h040,
    ST_TLOAD = 10'h080,
    ST_TX    = 10'h100,
    ST_TACK  = 10'h200
  } isc_state_e;

endpackage
`default_nettype wire

// ---- design/isc_irq_if.sv ----
// Purpose: carries event pulses, clears, enables and flag state between top and flag bank
// Assumes: single pclk domain
// Notes:   set and clr are one-cycle pulses per flag bit
`timescale 1ns/10ps
`default_nettype none
interface isc_irq_if;
  logic [isc_pkg::FLG_N-1:0] set;
  logic [isc_pkg::FLG_N-1:0] clr;
  logic [isc_pkg::FLG_N-1:0] mask;
  logic [isc_pkg::FLG_N-1:0] flags;
  logic                      irq;

  modport ctrl (output set, output clr, output mask, input flags, input irq);
  modport bank (input set, input clr, input mask, output flags, output irq);
endinterface
`default_nettype wire

// ---- design/isc_pin_sync.sv ----
// Purpose: two-stage synchroniser with optional glitch filter for one bus line
// Assumes: pin idles high (pulled up open-drain line)
// Notes:   filter adds FILT_CYC-1 cycles of latency while enabled
`timescale 1ns/10ps
`default_nettype none
module isc_pin_sync #(
  parameter int unsigned FILT_W   = 3,
  parameter int unsigned FILT_CYC = isc_pkg::FILT_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // line
  input  wire logic pin,
  input  wire logic filt_en,
  output logic      level
);

  typedef struct packed {
    logic              s1;
    logic              s2;
    logic              lvl;
    logic [FILT_W-1:0] cnt;
  } isc_sync_s;

  isc_sync_s r;
  isc_sync_s next_r;

  ////////////////////////////////////////////////////////////////////////////////
  // only s2 looks at s1; the filter needs a level stable for the whole window
  always_comb begin
    next_r    = r;
    next_r.s1 = pin;
    next_r.s2 = r.s1;
    if (!filt_en) begin
      next_r.lvl = r.s2;
      next_r.cnt = '0;
    end else if (r.s2 == r.lvl) begin
      next_r.cnt = '0;
    end else if (r.cnt == FILT_W'(FILT_CYC - 1)) begin
      next_r.lvl = r.s2;
      next_r.cnt = '0;
    end else begin
      next_r.cnt = r.cnt + FILT_W'(1);
    end
  end

  // idle-high reset so no false start is seen after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{s1: 1'b1, s2: 1'b1, lvl: 1'b1, cnt: '0};
    end else begin
      r <= next_r;
    end
  end

  assign level = r.lvl;

endmodule
`default_nettype wire

// ---- design/isc_irq_flags.sv ----
// Purpose: sticky event flags and masked interrupt level
// Assumes: set and clr pulses come from the same clock domain
// Notes:   a set in the cycle of a clear wins, so no event is lost
`timescale 1ns/10ps
`default_nettype none
module isc_irq_flags (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // flag traffic
  isc_irq_if.bank   bus
);

  typedef struct packed {
    logic [isc_pkg::FLG_N-1:0] flags;
  } isc_flags_s;

  isc_flags_s r;
  isc_flags_s next_r;

  ////////////////////////////////////////////////////////////////////////////////
  // set has priority over clear
  always_comb begin
    next_r       = r;
    next_r.flags = (r.flags & ~bus.clr) | bus.set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{flags: isc_pkg::FLG_RST};
    end else begin
      r <= next_r;
    end
  end

  // level stays high until every enabled flag is cleared
  assign bus.flags = r.flags;
  assign bus.irq   = |(r.flags & bus.mask);

endmodule
`default_nettype wire

// ---- design/isc_slave_top.sv ----
// Purpose: apb-controlled i2c slave with soft reset, per-event interrupt enables and stretching
// Assumes: scl and sda are open-drain lines; out pins are always zero, oe pulls the line low
// Notes:   zero-wait apb slave; read data captured in the setup cycle
//
// Behaviour
// - while soft reset is set, all sequencer state stays in reset, lines released.
// - writing one to soft reset clears the slave address and its enable.
// - address-match flag drives interrupt when its enable is set.
// - stop flag drives interrupt when its enable is set.
// - repeated-start flag drives interrupt when its enable is set.
// - transmit-byte flag drives interrupt when its enable is set.
// - receive-byte flag drives interrupt when its enable is set.
// - byte arrives with receive flag set: stretch if enabled, else NACK.
// - a stretched receive releases the clock once software clears the receive flag.
// - transmit with flag uncleared: stretch if enabled, else resend the old byte.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module isc_slave_top (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic [isc_pkg::APB_AW-1:0]   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // i2c lines
  input  wire logic                         scl_in,
  output logic                              scl_out,
  output logic                              scl_oe,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe,
  // interrupt
  output logic                              irq
);

  typedef struct packed {
    logic [7:0]          ctrl;
    logic [7:0]          addr;
    logic [7:0]          rx_data;
    logic [7:0]          tx_data;
    logic [7:0]          shift;
    logic [3:0]          cnt;
    isc_pkg::isc_state_e state;
    logic                xmt;
    logic                active;
    logic                sda_oe;
    logic                scl_oe;
    logic                scl_d;
    logic                sda_d;
    logic [31:0]         prdata;
  } isc_top_s;

  isc_top_s r;
  isc_top_s next_r;

  isc_irq_if irq_bus ();

  logic                      scl_l;
  logic                      sda_l;
  logic                      acc;
  logic                      wr_en;
  logic                      hit;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_c;
  logic                      stop_c;
  logic                      rx_full;
  logic                      tx_stale;
  logic                      stretch_en;
  logic [31:0]               rd_mux;
  logic [isc_pkg::FLG_N-1:0] ev_set;
  logic [isc_pkg::FLG_N-1:0] ev_clr;

  ////////////////////////////////////////////////////////////////////////////////
  // line synchronisers, filter steered by the control register
  isc_pin_sync #(
    .FILT_W   (3),
    .FILT_CYC (isc_pkg::FILT_CYC)
  ) u_scl_sync (
    .clk     (pclk),
    .rst_n   (presetn),
    .pin     (scl_in),
    .filt_en (r.ctrl[isc_pkg::CTRL_FILT]),
    .level   (scl_l)
  );

  isc_pin_sync #(
    .FILT_W   (3),
    .FILT_CYC (isc_pkg::FILT_CYC)
  ) u_sda_sync (
    .clk     (pclk),
    .rst_n   (presetn),
    .pin     (sda_in),
    .filt_en (r.ctrl[isc_pkg::CTRL_FILT]),
    .level   (sda_l)
  );

  isc_irq_flags u_flags (
    .clk   (pclk),
    .rst_n (presetn),
    .bus   (irq_bus.bank)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode and bus conditions
  assign acc        = psel & penable;
  assign wr_en      = acc & pwrite;
  assign hit        = (paddr == isc_pkg::OFS_CTRL) | (paddr == isc_pkg::OFS_ADDR) |
                      (paddr == isc_pkg::OFS_STAT) | (paddr == isc_pkg::OFS_DATA) |
                      (paddr == isc_pkg::OFS_MASK);
  assign scl_rise   = scl_l & ~r.scl_d;
  assign scl_fall   = ~scl_l & r.scl_d;
  assign start_c    = r.scl_d & scl_l & r.sda_d & ~sda_l;
  assign stop_c     = r.scl_d & scl_l & ~r.sda_d & sda_l;
  assign rx_full    = irq_bus.flags[isc_pkg::FLG_RX];
  assign tx_stale   = irq_bus.flags[isc_pkg::FLG_TX];
  assign stretch_en = r.ctrl[isc_pkg::CTRL_STRETCH];

  // read view; reserved bits read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      isc_pkg::OFS_CTRL: rd_mux[7:0] = r.ctrl;
      isc_pkg::OFS_ADDR: rd_mux[7:0] = r.addr;
      isc_pkg::OFS_STAT: begin
        rd_mux[isc_pkg::FLG_N-1:0] = irq_bus.flags;
        rd_mux[isc_pkg::STAT_XMT]  = r.xmt;
      end
      isc_pkg::OFS_DATA: rd_mux[7:0] = r.rx_data;
      isc_pkg::OFS_MASK: rd_mux[isc_pkg::FLG_N-1:0] = r.ctrl[isc_pkg::CTRL_EN_LSB +: isc_pkg::FLG_N];
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // write-one-to-clear on status; writing a new byte also retires the transmit flag
  always_comb begin
    ev_clr = '0;
    if (wr_en && paddr == isc_pkg::OFS_STAT) begin
      ev_clr = pwdata[isc_pkg::FLG_N-1:0];
    end
    if (wr_en && paddr == isc_pkg::OFS_DATA) begin
      ev_clr[isc_pkg::FLG_TX] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register file and slave sequencer
  always_comb begin
    next_r       = r;
    ev_set       = '0;
    next_r.scl_d = scl_l;
    next_r.sda_d = sda_l;

    // capture read data in the setup cycle so prdata is a flop at the access edge
    if (psel && !penable) begin
      next_r.prdata = rd_mux;
    end

    if (wr_en) begin
      case (paddr)
        isc_pkg::OFS_CTRL: begin
          next_r.ctrl = pwdata[7:0];
          if (pwdata[isc_pkg::CTRL_SRST]) begin
            next_r.addr = isc_pkg::ADDR_RST;
          end
        end
        isc_pkg::OFS_ADDR: next_r.addr = pwdata[7:0];
        isc_pkg::OFS_DATA: next_r.tx_data = pwdata[7:0];
        isc_pkg::OFS_MASK: next_r.ctrl[isc_pkg::CTRL_EN_LSB +: isc_pkg::FLG_N] = pwdata[isc_pkg::FLG_N-1:0];
        default: ;
      endcase
    end

    if (r.ctrl[isc_pkg::CTRL_SRST]) begin
      // held in reset; both lines released so the bus is never hung by software
      next_r.state  = isc_pkg::ST_IDLE;
      next_r.cnt    = 4'h0;
      next_r.shift  = 8'h00;
      next_r.xmt    = 1'b0;
      next_r.active = 1'b0;
      next_r.sda_oe = 1'b0;
      next_r.scl_oe = 1'b0;
    end else if (start_c) begin
      if (r.active) begin
        ev_set[isc_pkg::FLG_RESTART] = 1'b1;
      end
      next_r.state  = isc_pkg::ST_ADDR;
      next_r.cnt    = 4'h0;
      next_r.sda_oe = 1'b0;
      next_r.scl_oe = 1'b0;
    end else if (stop_c) begin
      if (r.active) begin
        ev_set[isc_pkg::FLG_STOP] = 1'b1;
      end
      next_r.state  = isc_pkg::ST_IDLE;
      next_r.active = 1'b0;
      next_r.sda_oe = 1'b0;
      next_r.scl_oe = 1'b0;
    end else begin
      case (r.state)
        isc_pkg::ST_IDLE: begin
          next_r.sda_oe = 1'b0;
          next_r.scl_oe = 1'b0;
        end
        isc_pkg::ST_ADDR: begin
          if (scl_rise) begin
            next_r.shift = {r.shift[6:0], sda_l};
            next_r.cnt   = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == 4'h8) begin
            if (r.addr[isc_pkg::ADDR_EN_BIT] && r.addr[6:0] == r.shift[7:1]) begin
              ev_set[isc_pkg::FLG_ADDR] = 1'b1;
              next_r.xmt    = r.shift[0];
              next_r.active = 1'b1;
              next_r.sda_oe = 1'b1;
              next_r.state  = isc_pkg::ST_AACK;
            end else begin
              next_r.active = 1'b0;
              next_r.state  = isc_pkg::ST_IDLE;
            end
          end
        end
        isc_pkg::ST_AACK: begin
          if (scl_fall) begin
            next_r.sda_oe = 1'b0;
            next_r.cnt    = 4'h0;
            next_r.state  = r.xmt ? isc_pkg::ST_TLOAD : isc_pkg::ST_RX;
          end
        end
        isc_pkg::ST_RX: begin
          if (scl_rise) begin
            next_r.shift = {r.shift[6:0], sda_l};
            next_r.cnt   = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == 4'h8) begin
            if (!rx_full) begin
              next_r.rx_data          = r.shift;
              ev_set[isc_pkg::FLG_RX] = 1'b1;
              next_r.sda_oe           = 1'b1;
              next_r.state            = isc_pkg::ST_RACK;
            end else if (stretch_en) begin
              next_r.scl_oe = 1'b1;
              next_r.state  = isc_pkg::ST_RSTR;
            end else begin
              next_r.state  = isc_pkg::ST_RNACK;
            end
          end
        end
        isc_pkg::ST_RSTR: begin
          // scl stays low until software drains the previous byte
          if (!rx_full) begin
            next_r.rx_data          = r.shift;
            ev_set[isc_pkg::FLG_RX] = 1'b1;
            next_r.sda_oe           = 1'b1;
            next_r.scl_oe           = 1'b0;
            next_r.state            = isc_pkg::ST_RACK;
          end
        end
        isc_pkg::ST_RACK, isc_pkg::ST_RNACK: begin
          if (scl_fall) begin
            next_r.sda_oe = 1'b0;
            next_r.cnt    = 4'h0;
            next_r.state  = isc_pkg::ST_RX;
          end
        end
        isc_pkg::ST_TLOAD: begin
          if (tx_stale && stretch_en) begin
            next_r.scl_oe = 1'b1;
          end else begin
            // without stretching a stale byte goes out again: data corruption by design
            next_r.scl_oe           = 1'b0;
            next_r.shift            = r.tx_data;
            ev_set[isc_pkg::FLG_TX] = 1'b1;
            next_r.sda_oe           = ~r.tx_data[7];
            next_r.cnt              = 4'h0;
            next_r.state            = isc_pkg::ST_TX;
          end
        end
        isc_pkg::ST_TX: begin
          if (scl_fall) begin
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == 4'h7) begin
              next_r.sda_oe = 1'b0;
              next_r.state  = isc_pkg::ST_TACK;
            end else begin
              next_r.shift  = {r.shift[6:0], 1'b0};
              next_r.sda_oe = ~r.shift[6];
            end
          end
        end
        isc_pkg::ST_TACK: begin
          // master nack ends the read; line stays free for stop or repeated start
          if (scl_rise && sda_l) begin
            next_r.state = isc_pkg::ST_IDLE;
          end else if (scl_fall) begin
            next_r.state = isc_pkg::ST_TLOAD;
          end
        end
        default: begin
          next_r.state  = isc_pkg::ST_IDLE;
          next_r.sda_oe = 1'b0;
          next_r.scl_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{ctrl: isc_pkg::CTRL_RST, addr: isc_pkg::ADDR_RST, rx_data: isc_pkg::DATA_RST,
             tx_data: isc_pkg::DATA_RST, shift: 8'h00, cnt: 4'h0, state: isc_pkg::ST_IDLE,
             xmt: 1'b0, active: 1'b0, sda_oe: 1'b0, scl_oe: 1'b0, scl_d: 1'b1, sda_d: 1'b1,
             prdata: 32'h0000_0000};
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign irq_bus.set  = ev_set;
  assign irq_bus.clr  = ev_clr;
  assign irq_bus.mask = r.ctrl[isc_pkg::CTRL_EN_LSB +: isc_pkg::FLG_N];
  assign irq          = irq_bus.irq;
  assign prdata       = r.prdata;
  assign pready       = 1'b1;              // zero-wait slave
  assign pslverr      = acc & ~hit;        // unmapped address
  assign scl_out      = 1'b0;              // open drain: only the enable matters
  assign sda_out      = 1'b0;
  assign scl_oe       = r.scl_oe;
  assign sda_oe       = r.sda_oe;

endmodule
`default_nettype wire

// ---- test/isc_checker.sv ----
// Purpose: port assertions for the i2c slave controller
// Assumes: apb writes land at the access edge, pready tied high
// Notes:   keeps its own shadow of ctrl and of the address enable
`timescale 1ns/10ps
`default_nettype none
module isc_checker (
  // clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // apb
  input wire logic [isc_pkg::APB_AW-1:0] paddr,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [31:0]                pwdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // lines and interrupt
  input wire logic                       scl_out,
  input wire logic                       scl_oe,
  input wire logic                       sda_out,
  input wire logic                       sda_oe,
  input wire logic                       irq
);
  logic [7:0] ctl;
  logic       a_en;
  logic       wr_ev;
  logic       mapped;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // shadows of ctrl and address enable
  assign wr_ev  = psel && penable && pwrite && pready;
  assign mapped = paddr inside {isc_pkg::OFS_CTRL, isc_pkg::OFS_ADDR, isc_pkg::OFS_STAT,
                                isc_pkg::OFS_DATA, isc_pkg::OFS_MASK};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl  <= 8'h00;
      a_en <= 1'b0;
    end else if (wr_ev) begin
      if (paddr == isc_pkg::OFS_CTRL) ctl <= pwdata[7:0];
      if (paddr == isc_pkg::OFS_MASK) ctl[6:2] <= pwdata[4:0];
      if (paddr == isc_pkg::OFS_ADDR) a_en <= pwdata[7];
      if (paddr == isc_pkg::OFS_CTRL && pwdata[7]) a_en <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence acc_s;
    psel && penable;
  endsequence
  sequence srst_wr_s;
    wr_ev && paddr == isc_pkg::OFS_CTRL && pwdata[7];
  endsequence
  pready_high_a: assert property (pready)
    else $error("pready low");
  pins_zero_a: assert property (!scl_out && !sda_out)
    else $error("line output value not zero");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  unmapped_err_a: assert property (acc_s ##0 !mapped |-> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (acc_s ##0 mapped |-> !pslverr)
    else $error("mapped access flagged");
  srst_rel_a: assert property (srst_wr_s |=> ##1 (!scl_oe && !sda_oe))
    else $error("lines held after soft reset");
  srst_hold_a: assert property (ctl[7] && $past(ctl[7]) |-> !scl_oe && !sda_oe)
    else $error("line driven in soft reset");
  ack_addr_a: assert property ($rose(sda_oe) |-> a_en)
    else $error("sda driven with address disabled");
  irq_needs_en_a: assert property (irq |-> |ctl[6:2])
    else $error("interrupt with no enable");
  stretch_en_a: assert property ($rose(scl_oe) |-> ctl[1])
    else $error("stretch while disabled");
endmodule

bind isc_slave_top isc_checker u_isc_checker (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
  .pready, .pslverr, .scl_out, .scl_oe, .sda_out, .sda_oe, .irq);
`default_nettype wire

// ---- test/isc_i2c_master.sv ----
// Purpose: behavioural i2c master on the slave's open-drain lines
// Assumes: lines pulled up
// Notes:   Q pclk cycles per quarter bit; a stuck scl sets hang
`timescale 1ns/10ps
`default_nettype none
module isc_i2c_master #(
  parameter int unsigned Q = 10
) (
  // clock
  input  wire logic clk,
  // bus lines
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  logic hang;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hang    = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic qtr();
    repeat (Q) @(posedge clk);
  endtask
  // release scl, wait out a bounded stretch
  task automatic rise();
    int n;
    scl_low <= 1'b0;
    for (n = 0; n < 4000 && scl !== 1'b1; n++) @(posedge clk);
    if (n == 4000) hang <= 1'b1;
  endtask
  // also a repeated start
  task automatic start();
    sda_low <= 1'b0;
    qtr();
    rise();
    qtr();
    sda_low <= 1'b1;
    qtr();
    scl_low <= 1'b1;
    qtr();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    qtr();
    rise();
    qtr();
    sda_low <= 1'b0;
    qtr();
  endtask
  // msb first, then ack; 8'hff reads, ai high nacks
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] r, output logic ao);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= (i > 0) ? !d[i-1] : !ai;
      qtr();
      rise();
      qtr();
      if (i > 0) r[i-1] = sda;
      else ao = sda;
      qtr();
      scl_low <= 1'b1;
      qtr();
    end
  endtask
endmodule
`default_nettype wire

// ---- test/isc_slave_top_tb.sv ----
// Purpose: self-checking bench for the i2c slave controller
// Assumes: filter off, slave address 7'h2a
// Notes:   tx stretching is left to the checker alone
`timescale 1ns/10ps
`default_nettype none
module isc_slave_top_tb;
  localparam logic [6:0] SA = 7'h2a;
  logic [isc_pkg::APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
  logic        scl, sda, scl_out, scl_oe, sda_out, sda_oe, irq, m_scl_low, m_sda_low, ak, seen;
  logic [7:0]  q8;
  int          fails, n_tests;
  // open-drain wire-and with pull-ups
  assign scl = !(scl_oe || m_scl_low);
  assign sda = !(sda_oe || m_sda_low);
  always #5 pclk = ~pclk;
  isc_slave_top u_isc_slave_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe, .irq);
  isc_i2c_master u_isc_i2c_master (.clk(pclk), .scl, .sda, .scl_low(m_scl_low), .sda_low(m_sda_low));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    {rdv, erv} = {prdata, pslverr};
    if (n == 50) begin
      fails++;
      print_verdict();
    end
    {psel, penable} <= 2'b00;
    @(negedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  // one byte with expected ack and read data
  task automatic xb(input logic [7:0] d, input logic ai, input logic ea, input logic [7:0] eq);
    u_isc_i2c_master.xfer(d, ai, q8, ak);
    chk({31'h0, ak}, {31'h0, ea});
    if (d == 8'hff) chk({24'h0, q8}, {24'h0, eq});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // hang and run-length guards
  always @(posedge pclk) if (u_isc_i2c_master.hang === 1'b1) begin
    fails++;
    print_verdict();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    fails++;
    print_verdict();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, fails, n_tests} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({rdv[30:0], erv}, 32'h1);
    wr(isc_pkg::OFS_ADDR, {24'h0, 1'b1, SA});
    wr(isc_pkg::OFS_DATA, 32'h96);
    // all events, then each enable alone
    u_isc_i2c_master.start();
    xb({SA, 1'b0}, 1'b1, 1'b0, 8'h00);
    xb(8'hc3, 1'b1, 1'b0, 8'h00);
    u_isc_i2c_master.start();
    xb({SA, 1'b1}, 1'b1, 1'b0, 8'h00);
    xb(8'hff, 1'b1, 1'b1, 8'h96);
    u_isc_i2c_master.stop();
    apb(1'b0, isc_pkg::OFS_STAT, 32'h0);
    chk(rdv & 32'h1f, 32'h1f);
    rd(isc_pkg::OFS_DATA, 32'hc3);
    chk({31'h0, irq}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(isc_pkg::OFS_MASK, 32'(1 << i));
      chk({31'h0, irq}, 32'h1);
      rd(isc_pkg::OFS_CTRL, 32'(4 << i));
      wr(isc_pkg::OFS_STAT, 32'(1 << i));
      chk({31'h0, irq}, 32'h0);
    end
    // overrun without stretching: nack, byte dropped
    u_isc_i2c_master.start();
    xb({SA, 1'b0}, 1'b1, 1'b0, 8'h00);
    xb(8'h11, 1'b1, 1'b0, 8'h00);
    xb(8'h22, 1'b1, 1'b1, 8'h00);
    u_isc_i2c_master.stop();
    rd(isc_pkg::OFS_DATA, 32'h11);
    wr(isc_pkg::OFS_STAT, 32'h1f);
    // overrun with stretch, freed by receive clear
    wr(isc_pkg::OFS_CTRL, 32'h02);
    u_isc_i2c_master.start();
    xb({SA, 1'b0}, 1'b1, 1'b0, 8'h00);
    xb(8'h33, 1'b1, 1'b0, 8'h00);
    seen = 1'b0;
    fork
      u_isc_i2c_master.xfer(8'h44, 1'b1, q8, ak);
      begin
        for (int n = 0; n < 3000 && seen !== 1'b1; n++) @(posedge pclk) seen = scl_oe;
        wr(isc_pkg::OFS_STAT, 32'h01);
      end
    join
    chk({31'h0, seen}, 32'h1);
    chk({31'h0, ak}, 32'h0);
    u_isc_i2c_master.stop();
    rd(isc_pkg::OFS_DATA, 32'h44);
    // stale tx flag, no stretch: old byte resent
    wr(isc_pkg::OFS_CTRL, 32'h00);
    wr(isc_pkg::OFS_STAT, 32'h1f);
    wr(isc_pkg::OFS_DATA, 32'h5c);
    u_isc_i2c_master.start();
    xb({SA, 1'b1}, 1'b1, 1'b0, 8'h00);
    xb(8'hff, 1'b0, 1'b0, 8'h5c);
    xb(8'hff, 1'b1, 1'b1, 8'h5c);
    u_isc_i2c_master.stop();
    // soft reset clears address, slave deaf
    wr(isc_pkg::OFS_CTRL, 32'h80);
    rd(isc_pkg::OFS_ADDR, 32'h0);
    wr(isc_pkg::OFS_ADDR, {24'h0, 1'b1, SA});
    u_isc_i2c_master.start();
    xb({SA, 1'b0}, 1'b1, 1'b1, 8'h00);
    u_isc_i2c_master.stop();
    wr(isc_pkg::OFS_CTRL, 32'h00);
    u_isc_i2c_master.start();
    xb({SA, 1'b0}, 1'b1, 1'b0, 8'h00);
    u_isc_i2c_master.stop();
    print_verdict();
  end
endmodule
`default_nettype wire
